// *** dv/blfg_core_model.sv ***
// processor core model issuing store and load requests
// assumes requests are taken on the rising edge of clk_i
`timescale 1ns/1ns
`default_nettype none
module blfg_core_model (
    input wire logic clk_i,
    output logic [15:0] pc_o,
    output logic st_req_o,
    output logic [1:0] st_op_o,
    output logic [7:0] st_data_o,
    output logic ld_req_o
);
    // ****
    // request tasks
    // ****
    initial
    begin
        pc_o = 16'h0000;
        st_req_o = 1'b0;
        st_op_o = 2'h0;
        st_data_o = 8'hFF;
        ld_req_o = 1'b0;
    end
    // caller keeps the store spacing; released data toggles so nothing stale is read
    task store(input logic [15:0] pc, input logic [1:0] op, input logic [7:0] d);
        @(posedge clk_i);
        pc_o <= pc;
        st_op_o <= op;
        st_data_o <= d;
        st_req_o <= 1'b1;
        @(posedge clk_i);
        st_req_o <= 1'b0;
        st_data_o <= ~d;
    endtask
    task load(input logic [15:0] pc);
        @(posedge clk_i);
        pc_o <= pc;
        ld_req_o <= 1'b1;
        @(posedge clk_i);
        ld_req_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** dv/blfg_top_props.sv ***
// checker for the boot lock flash guard ports
// assumes one clock domain and the 1-cycle answers of the hand-over
`timescale 1ns/1ns
`default_nettype none
module blfg_props #(
    parameter [15:0] BOOT_START = 16'h0C00
) (
    input wire ref_clk_i,
    input wire nrst_i,
    input wire [15:0] exec_pc_i,
    input wire irq_vec_in_boot_i,
    input wire irq_enable_i,
    input wire irq_allow_o,
    input wire store_req_i,
    input wire [1:0] store_op_i,
    input wire load_req_i,
    input wire boot_reset_select_i,
    input wire [15:0] reset_vector_o,
    input wire flash_op_o,
    input wire load_grant_o,
    input wire [15:0] load_byte_addr_o,
    input wire load_high_byte_o,
    input wire load_blocked_o
);
    // ****
    // properties
    // ****
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    chk_app_store_ignored: assert property (store_req_i && exec_pc_i < BOOT_START |=> !flash_op_o)
        else $error("store from application started flash");
    chk_lock_op_quiet: assert property (store_req_i && store_op_i == 2'h3 |=> !flash_op_o)
        else $error("lock store started flash");
    chk_op_has_cause: assert property (flash_op_o |-> $past(store_req_i) && $past(exec_pc_i) >= BOOT_START)
        else $error("flash op without boot store");
    chk_load_one_answer: assert property (load_req_i |=> load_grant_o != load_blocked_o)
        else $error("load not answered once");
    chk_load_no_stray: assert property (!load_req_i |=> !(load_grant_o || load_blocked_o))
        else $error("load answer without request");
    chk_byte_select: assert property (load_grant_o |-> load_high_byte_o == load_byte_addr_o[0])
        else $error("byte select differs from bit 0");
    chk_irq_gate: assert property (irq_allow_o |-> irq_enable_i)
        else $error("interrupt allowed while disabled");
    chk_irq_boot_home: assert property (irq_enable_i && irq_vec_in_boot_i && exec_pc_i >= BOOT_START |-> irq_allow_o)
        else $error("interrupt masked with vectors in own section");
    chk_irq_app_home: assert property (irq_enable_i && !irq_vec_in_boot_i && exec_pc_i < BOOT_START |-> irq_allow_o)
        else $error("interrupt masked with vectors in own section");
    chk_vec_app: assert property (boot_reset_select_i [*5] |-> reset_vector_o == 16'h0000)
        else $error("reset vector not zero");
    chk_vec_boot: assert property ((!boot_reset_select_i) [*5] |-> reset_vector_o == BOOT_START)
        else $error("reset vector not boot start");
    cover property (flash_op_o);
    cover property (load_blocked_o);
    cover property (irq_enable_i && !irq_allow_o);
endmodule
bind blfg_top blfg_props #(.BOOT_START(BOOT_START)) props_u (.*);
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the boot lock flash guard
// assumes the core model in dv and a 125 MHz reference clock
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic irq_vb = 1'b1;
    logic irq_en = 1'b1;
    logic ce = 1'b0;
    logic fuse = 1'b1;
    logic [7:0] rdata;
    logic [7:0] sdat;
    logic [15:0] pc, rvec, lba;
    logic [1:0] sop, fcode;
    logic sreq, lreq, irq_ok, fop, lg, lhb, lbl;
    logic [9:0] page;
    logic [4:0] wrd;
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
    always #4 clk = ~clk;
    blfg_core_model core_u (.clk_i(clk), .pc_o(pc), .st_req_o(sreq), .st_op_o(sop), .st_data_o(sdat), .ld_req_o(lreq));
    blfg_top dut_u (.ref_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .exec_pc_i(pc), .irq_vec_in_boot_i(irq_vb), .irq_enable_i(irq_en),
        .irq_allow_o(irq_ok), .store_req_i(sreq), .store_op_i(sop), .store_lock_data_i(sdat), .load_req_i(lreq),
        .chip_erase_i(ce), .boot_reset_select_i(fuse), .ext_lock_mode_i(2'h3), .reset_vector_o(rvec),
        .flash_op_o(fop), .flash_op_code_o(fcode), .page_select_field_o(page), .word_in_page_field_o(wrd),
        .load_grant_o(lg), .load_byte_addr_o(lba), .load_high_byte_o(lhb), .load_blocked_o(lbl));
    // ****
    // access and compare tasks
    // ****
    task chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rreg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, e});
    endtask
    task setp(input logic [15:0] p);
        wreg(4'h0, p[7:0]);
        wreg(4'h1, p[15:8]);
    endtask
    // spacing of 5 cycles keeps clear of the busy window
    task st(input logic [15:0] p, input logic [1:0] op, input logic [7:0] d, input logic e);
        core_u.store(p, op, d);
        #1 chk({15'h0000, fop}, {15'h0000, e});
        repeat (5) @(posedge clk);
    endtask
    task ld(input logic [15:0] p, input logic g);
        core_u.load(p);
        #1 chk({14'h0000, lg, lbl}, {14'h0000, g, !g});
    endtask
    task conclude;
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            mismatches++;
            conclude;
        end
    end
    // ****
    // test sequence
    // ****
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rreg(4'h2, 8'hFF);
        rreg(4'hF, 8'h00);
        chk(rvec, 16'h0000);
        setp(16'h0A66);
        st(16'h0100, 2'h0, 8'hFF, 1'b0);
        rreg(4'h3, 8'h08);
        wreg(4'h3, 8'h08);
        for (int i = 0; i < 3; i++)
        begin
            st(16'h0C00, i[1:0], 8'hFF, 1'b1);
            chk({14'h0000, fcode}, i[15:0]);
            chk({1'b0, page, wrd}, {1'b0, 10'h029, 5'h13});
        end
        setp(16'h1FFE);
        chk({1'b0, page, wrd}, {1'b0, 10'h029, 5'h13});
        rreg(4'h4, 8'h66);
        rreg(4'h5, 8'h0A);
        setp(16'h0A66);
        st(16'h0C00, 2'h3, 8'hF3, 1'b0);
        rreg(4'h2, 8'hF3);
        st(16'h0C00, 2'h2, 8'hFF, 1'b0);
        rreg(4'h3, 8'h02);
        wreg(4'h3, 8'h02);
        ld(16'h0C00, 1'b0);
        chk({15'h0000, irq_ok}, 16'h0001);
        @(posedge clk);
        irq_en <= 1'b0;
        @(posedge clk);
        #1 chk({15'h0000, irq_ok}, 16'h0000);
        @(posedge clk);
        irq_en <= 1'b1;
        ld(16'h0100, 1'b1);
        chk({15'h0000, irq_ok}, 16'h0000);
        setp(16'h1A66);
        st(16'h0C00, 2'h2, 8'hFF, 1'b1);
        st(16'h0C00, 2'h3, 8'hDF, 1'b0);
        st(16'h0C00, 2'h3, 8'hFF, 1'b0);
        rreg(4'h2, 8'hD3);
        st(16'h0C00, 2'h1, 8'hFF, 1'b1);
        ld(16'h0100, 1'b0);
        @(posedge clk);
        irq_vb <= 1'b0;
        ld(16'h0C00, 1'b1);
        chk({15'h0000, irq_ok}, 16'h0000);
        st(16'h0C00, 2'h3, 8'hEF, 1'b0);
        st(16'h0C00, 2'h0, 8'hFF, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        rreg(4'h2, 8'hFF);
        setp(16'h0A67);
        ld(16'h0C00, 1'b1);
        chk({lhb, lba[14:0]}, {1'b1, 15'h0A67});
        @(posedge clk);
        fuse <= 1'b0;
        repeat (5) @(posedge clk);
        #1 chk(rvec, 16'h0C00);
        conclude;
    end
endmodule
`default_nettype wire

// *** rtl/blfg_top.v ***
// boot lock flash guard: lock checks, reset vector and flash addressing
// assumes the core gives single-cycle store and load requests on ref_clk_i
// Overview of operation
// R1: two independent lock fields, app and boot
// R2: software only programs lock bits; erase clears
// R3: general write lock ignored by store path
// R4: general read/write lock ignored by store/load
// R5: app mode 1 leaves app unrestricted
// R6: app modes 2,3 block stores to app
// R7: app modes 3,4 block boot loads of app
// R8: app modes 3,4 mask irq in app
// R9: boot mode 1 leaves boot unrestricted
// R10: boot modes 2,3 block stores to boot
// R11: boot modes 3,4 block app loads of boot
// R12: boot modes 3,4 mask irq in boot
// R13: reset fuse selects 0x0000 or boot start
// R14: software cannot alter fuses
// R15: store address from 16-bit pointer pair
// R16: address splits into page and word fields
// R17: software uses same page for erase/write
// R18: address latched when operation starts
// R19: lock-setting store ignores the pointer
// R20: load addresses bytes using pointer bit 0
// R21: stores from application section are ignored
// R22: blocked access leaves flash untouched
`timescale 1ns/1ns
`include "blfg_regs.vh"
`default_nettype none
module blfg_top #(
    parameter ADDR_W = 16,
    parameter WORD_BITS = 5,
    parameter [15:0] BOOT_START = 16'h0C00,
    parameter [15:0] IRQ_VEC_BOOT = 16'h0C00
) (
    input wire ref_clk_i,
    input wire nrst_i,
    input wire [3:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire [15:0] exec_pc_i,
    input wire irq_vec_in_boot_i,
    input wire irq_enable_i,
    output wire irq_allow_o,
    input wire store_req_i,
    input wire [1:0] store_op_i,
    input wire [7:0] store_lock_data_i,
    input wire load_req_i,
    input wire chip_erase_i,
    input wire boot_reset_select_i,
    input wire [1:0] ext_lock_mode_i,
    output reg [15:0] reset_vector_o,
    output reg flash_op_o,
    output reg [1:0] flash_op_code_o,
    output reg [ADDR_W-WORD_BITS-2:0] page_select_field_o,
    output reg [WORD_BITS-1:0] word_in_page_field_o,
    output reg load_grant_o,
    output reg [ADDR_W-1:0] load_byte_addr_o,
    output reg load_high_byte_o,
    output reg load_blocked_o
);
    // ************************************************************
    // section decode
    // ************************************************************
    function in_boot;
        input [15:0] word_addr;
        begin
            in_boot = (word_addr >= BOOT_START);
        end
    endfunction

    // one decode for every register write hit
    function reg_hit;
        input wr;
        input [3:0] addr;
        input [3:0] target;
        begin
            reg_hit = wr & (addr == target);
        end
    endfunction

    // limitation: boot size fixed by BOOT_START, no size fuses here
    localparam PAGE_W = ADDR_W - WORD_BITS - 1;

    reg [7:0] addr_pointer_low_r;
    reg [7:0] addr_pointer_high_r;
    reg [7:0] lock_r;
    reg [15:0] latched_addr_r;
    reg [7:0] busy_cnt_r;
    reg wr_blocked_r;
    reg rd_blocked_r;
    reg ignored_r;
    reg fuse_sync1_r;
    reg fuse_sync2_r;
    reg erase_sync1_r;
    reg erase_sync2_r;
    reg [7:0] busy_cnt_nxt;
    reg [7:0] rdata_nxt;

    // pointer pair forms the flash address [R15]
    wire [15:0] pointer = {addr_pointer_high_r, addr_pointer_low_r};
    wire [15:0] ptr_word = {1'b0, pointer[15:1]};
    wire app_lock_hi = lock_r[`BLFG_LOCK_APP_HI];
    wire app_lock_lo = lock_r[`BLFG_LOCK_APP_LO];
    wire boot_lock_hi = lock_r[`BLFG_LOCK_BOOT_HI];
    wire boot_lock_lo = lock_r[`BLFG_LOCK_BOOT_LO];
    wire exec_boot = in_boot(exec_pc_i);
    wire tgt_boot = in_boot(ptr_word);
    // ext_lock_mode_i deliberately never reaches the checks [R3] [R4]
    // mode 1 means both bits unprogrammed, so no term below fires [R5] [R9]
    wire app_wr_lock = ~app_lock_lo;  // [R6]
    wire boot_wr_lock = ~boot_lock_lo;  // [R10]
    wire app_rd_lock = ~app_lock_hi;  // [R7]
    wire boot_rd_lock = ~boot_lock_hi;  // [R11]
    wire busy = (busy_cnt_r != 8'h00);
    wire is_lock_op = (store_op_i == `BLFG_OP_LOCK);
    wire store_take = store_req_i & ~busy & exec_boot;  // [R21]
    wire store_ign = store_req_i & (busy | ~exec_boot);
    wire wr_block = ~is_lock_op & (tgt_boot ? boot_wr_lock : app_wr_lock);
    wire rd_block = exec_boot ? (~tgt_boot & app_rd_lock) : (tgt_boot & boot_rd_lock);
    wire take_ok = store_take & ~wr_block;
    // lock-setting store never reads the pointer [R19]
    wire latch_addr = take_ok & ~is_lock_op;

    // ************************************************************
    // register write decode
    // ************************************************************
    wire ptr_lo_wr = reg_hit(reg_wr_i, reg_addr_i, `BLFG_ADDR_PTR_LOW);
    wire ptr_hi_wr = reg_hit(reg_wr_i, reg_addr_i, `BLFG_ADDR_PTR_HIGH);
    wire status_wr = reg_hit(reg_wr_i, reg_addr_i, `BLFG_ADDR_STATUS);

    // ************************************************************
    // interrupt masking when vectors sit in the other section
    // ************************************************************
    wire irq_mask_app = irq_vec_in_boot_i & ~exec_boot & app_rd_lock;  // [R8]
    wire irq_mask_boot = ~irq_vec_in_boot_i & exec_boot & boot_rd_lock;  // [R12]
    assign irq_allow_o = irq_enable_i & ~irq_mask_app & ~irq_mask_boot;

    // ************************************************************
    // fuse pin synchroniser
    // ************************************************************
    // fuse resets to unprogrammed so reset lands in the application
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            fuse_sync1_r <= 1'b1;
            fuse_sync2_r <= 1'b1;
        end
        else
        begin
            fuse_sync1_r <= boot_reset_select_i;
            fuse_sync2_r <= fuse_sync1_r;
        end
    end

    // ************************************************************
    // chip erase synchroniser
    // ************************************************************
    // erase is a level; a pulse shorter than a clock may be missed
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            erase_sync1_r <= 1'b0;
            erase_sync2_r <= 1'b0;
        end
        else
        begin
            erase_sync1_r <= chip_erase_i;
            erase_sync2_r <= erase_sync1_r;
        end
    end

    // fuse only comes from the pin, no register writes it [R14]
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            reset_vector_o <= `BLFG_APP_RESET_VEC;
        else
            reset_vector_o <= fuse_sync2_r ? `BLFG_APP_RESET_VEC : BOOT_START;  // [R13]
    end

    // ************************************************************
    // lock bits and pointer registers
    // ************************************************************
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            lock_r <= `BLFG_LOCK_RESET;
        else if (erase_sync2_r)
            lock_r <= `BLFG_LOCK_RESET;  // [R2]
        else if (store_take & is_lock_op)
            // bits only go to programmed, fields independent [R1] [R2]
            lock_r <= lock_r & (store_lock_data_i | 8'hC3);
    end

    // pointer pair is plain storage; ops copy it when they start
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            addr_pointer_low_r <= 8'h00;
            addr_pointer_high_r <= 8'h00;
        end
        else
        begin
            if (ptr_lo_wr)
                addr_pointer_low_r <= reg_wdata_i;
            if (ptr_hi_wr)
                addr_pointer_high_r <= reg_wdata_i;
        end
    end

    // ************************************************************
    // store path: busy window
    // ************************************************************
    // one op at a time; a store inside the window is refused, not queued
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            busy_cnt_r <= 8'h00;
        else
            busy_cnt_r <= busy_cnt_nxt;
    end

    always @*
    begin
        busy_cnt_nxt = busy_cnt_r;
        if (take_ok)
            busy_cnt_nxt = `BLFG_BUSY_CYCLES;
        else if (busy)
            busy_cnt_nxt = busy_cnt_r - 8'h01;
    end

    // ************************************************************
    // store path: sticky status flags
    // ************************************************************
    // set beats clear so a refusal in the clearing cycle is not lost
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ignored_r <= 1'b0;
            wr_blocked_r <= 1'b0;
        end
        else
        begin
            if (store_ign)
                ignored_r <= 1'b1;  // [R21]
            else if (status_wr & reg_wdata_i[`BLFG_ST_IGNORED])
                ignored_r <= 1'b0;
            if (store_take & wr_block)
                wr_blocked_r <= 1'b1;  // [R22]
            else if (status_wr & reg_wdata_i[`BLFG_ST_WR_BLOCKED])
                wr_blocked_r <= 1'b0;
        end
    end

    // ************************************************************
    // store path: issue pulse and op code
    // ************************************************************
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            flash_op_o <= 1'b0;
            flash_op_code_o <= `BLFG_OP_ERASE;
        end
        else
        begin
            // lock-setting store runs without touching the array [R19]
            flash_op_o <= latch_addr;
            if (take_ok)
                flash_op_code_o <= store_op_i;
        end
    end

    // ************************************************************
    // store path: address latch
    // ************************************************************
    // pointer is free for other use once the op has started
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            latched_addr_r <= 16'h0000;
            page_select_field_o <= {PAGE_W{1'b0}};
            word_in_page_field_o <= {WORD_BITS{1'b0}};
        end
        else if (latch_addr)
        begin
            latched_addr_r <= pointer;  // [R18]
            // word and page fields of the word address [R16]
            word_in_page_field_o <= pointer[WORD_BITS:1];
            page_select_field_o <= pointer[ADDR_W-1:WORD_BITS+1];
        end
    end

    // ************************************************************
    // load path: answer pulses
    // ************************************************************
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            load_grant_o <= 1'b0;
            load_blocked_o <= 1'b0;
        end
        else
        begin
            load_grant_o <= load_req_i & ~rd_block;  // [R7] [R11]
            load_blocked_o <= load_req_i & rd_block;  // [R22]
        end
    end

    // ************************************************************
    // load path: byte address
    // ************************************************************
    // address passes even when blocked; only the grant opens the read
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            load_byte_addr_o <= {ADDR_W{1'b0}};
            load_high_byte_o <= 1'b0;
        end
        else if (load_req_i)
        begin
            load_byte_addr_o <= pointer;
            load_high_byte_o <= pointer[0];  // [R20]
        end
    end

    // sticky read refusal, set wins over clear
    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rd_blocked_r <= 1'b0;
        else if (load_req_i & rd_block)
            rd_blocked_r <= 1'b1;
        else if (status_wr & reg_wdata_i[`BLFG_ST_RD_BLOCKED])
            rd_blocked_r <= 1'b0;
    end

    // ************************************************************
    // register read port
    // ************************************************************
    // data holds between reads so a slow master still sees it
    always @*
    begin
        rdata_nxt = reg_rdata_o;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `BLFG_ADDR_PTR_LOW: rdata_nxt = addr_pointer_low_r;
                `BLFG_ADDR_PTR_HIGH: rdata_nxt = addr_pointer_high_r;
                `BLFG_ADDR_LOCK: rdata_nxt = lock_r;
                `BLFG_ADDR_STATUS: rdata_nxt = {4'h0, ignored_r, rd_blocked_r, wr_blocked_r, busy};
                `BLFG_ADDR_LATCHED_LO: rdata_nxt = latched_addr_r[7:0];
                `BLFG_ADDR_LATCHED_HI: rdata_nxt = latched_addr_r[15:8];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= rdata_nxt;
    end
endmodule
`default_nettype wire

// *** shared/blfg_regs.vh ***
// constants for the boot lock flash guard
// assumes word-addressed flash split into application and boot sections
`ifndef BLFG_REGS_VH
`define BLFG_REGS_VH
// ************************************************************
// register map on the plain port
// ************************************************************
`define BLFG_ADDR_PTR_LOW     4'h0
`define BLFG_ADDR_PTR_HIGH    4'h1
`define BLFG_ADDR_LOCK        4'h2
`define BLFG_ADDR_STATUS      4'h3
`define BLFG_ADDR_LATCHED_LO  4'h4
`define BLFG_ADDR_LATCHED_HI  4'h5
`define BLFG_ADDR_W           4
// ************************************************************
// lock register fields
// ************************************************************
`define BLFG_LOCK_APP_LO      2
`define BLFG_LOCK_APP_HI      3
`define BLFG_LOCK_BOOT_LO     4
`define BLFG_LOCK_BOOT_HI     5
`define BLFG_LOCK_RESET       8'hFF
// ************************************************************
// status register fields
// ************************************************************
`define BLFG_ST_BUSY          0
`define BLFG_ST_WR_BLOCKED    1
`define BLFG_ST_RD_BLOCKED    2
`define BLFG_ST_IGNORED       3
// ************************************************************
// store operation codes and reset values
// ************************************************************
`define BLFG_OP_ERASE         2'h0
`define BLFG_OP_FILL          2'h1
`define BLFG_OP_WRITE         2'h2
`define BLFG_OP_LOCK          2'h3
`define BLFG_APP_RESET_VEC    16'h0000
`define BLFG_BUSY_CYCLES      8'h04
`endif
